// ### logic/cse_addr_gen.sv
// Operand address former for byte-oriented instructions
`timescale 1ns/1ps
`default_nettype none
module cse_addr_gen
    import cse_pkg::*;
(
    input wire logic [7:0] field,
    input wire logic access_sel,
    input wire logic [3:0] bank_select_register,
    input wire logic ext_enable,
    input wire logic [11:0] index_base,
    output logic [11:0] addr
);
    wire logic use_indexed;
    wire logic [11:0] access_addr;
    wire logic [11:0] banked_addr;
    wire logic [11:0] indexed_addr;
    assign use_indexed = ext_enable && !access_sel
        && (field <= CSE_ILO_MAX);
    // Low 96 bytes of access bank are bank 0, the rest the top bank
    assign access_addr = (field < CSE_ACCESS_SPLIT) ? {4'h0, field}
        : {CSE_ACCESS_HI_BANK, field};
    assign banked_addr = {bank_select_register, field};
    assign indexed_addr = index_base + {4'h0, field};
    assign addr = use_indexed ? indexed_addr
        : (access_sel ? banked_addr : access_addr);
endmodule
`default_nettype wire

// ### logic/cse_exec.sv
// Execute stage for compare-skip-if-equal and complement instructions
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Opcode 0110001a compares byte with working register
// - Equal discards fetched instruction, runs no-operation
// - One word; one cycle, two when skipping
// - Skip over two-word instruction takes three
// - Two dead cycles after skip of long
// - Access bit 0 selects access bank
// - Access bit 1 uses bank select register
// - Extended set, access bit 0, field up to 95: indexed
// - Complement to working register keeps source
// - Complement inverts; destination bit picks target
module cse_exec
    import cse_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] q_phase,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic [15:0] next_word,
    input wire logic [3:0] bank_select_register,
    input wire logic ext_enable,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] working_register_alias,
    output logic [11:0] mem_addr,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic work_we,
    output logic [7:0] work_wdata,
    output logic instr_nop,
    output logic skip_taken,
    output logic busy
);
    // ==================================================
    // Decode
    wire logic is_cmp;
    wire logic is_comp;
    wire logic next_is_long;
    wire logic [11:0] op_addr;
    wire logic cycle_end;
    wire logic [7:0] comp_value;
    wire logic equal;
    wire logic [8:0] diff;
    cse_state_t state;
    cse_state_t next_state;
    logic [11:0] next_mem_addr;

    assign is_cmp = instr_valid && (state == CSE_RUN)
        && (instr[15:9] == CSE_OP_CMP_EQ);
    assign is_comp = instr_valid && (state == CSE_RUN)
        && (instr[15:10] == CSE_OP_COMP);
    assign next_is_long = (next_word[15:12] == CSE_OP_LONG);
    assign cycle_end = (q_phase == CSE_PHASE_LAST);
    // Unsigned subtraction; only the zero result matters
    assign diff = {1'b0, mem_rdata} - {1'b0, working_register_alias};
    assign equal = (diff == 9'h000);
    assign comp_value = ~mem_rdata;

    cse_addr_gen u_addr (
        .field(instr[7:0]),
        .access_sel(instr[8]),
        .bank_select_register(bank_select_register),
        .ext_enable(ext_enable),
        .index_base(index_base),
        .addr(op_addr)
    );

    // ==================================================
    // Skip sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            CSE_RUN: begin
                if (is_cmp && cycle_end && equal) begin
                    next_state = CSE_KILL1;
                end
            end
            CSE_KILL1: begin
                if (cycle_end) begin
                    // Long skipped word costs one more dead cycle
                    next_state = (instr_valid && next_is_long)
                        ? CSE_KILL2 : CSE_RUN;
                end
            end
            CSE_KILL2: begin
                if (cycle_end) begin
                    next_state = CSE_RUN;
                end
            end
            default: next_state = CSE_RUN;
        endcase
    end

    assign next_mem_addr = (is_cmp || is_comp) ? op_addr : mem_addr;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= CSE_RUN;
            mem_addr <= CSE_ADDR_RESET;
        end else begin
            state <= next_state;
            mem_addr <= next_mem_addr;
        end
    end

    // ==================================================
    // Writeback: compare never writes memory or the working register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_we <= 1'b0;
            mem_wdata <= CSE_BYTE_RESET;
            work_we <= 1'b0;
            work_wdata <= CSE_BYTE_RESET;
            instr_nop <= 1'b0;
            skip_taken <= 1'b0;
            busy <= 1'b0;
        end else begin
            mem_we <= is_comp && instr[9]
                && (q_phase == CSE_PHASE_READ);
            work_we <= is_comp && !instr[9]
                && (q_phase == CSE_PHASE_READ);
            mem_wdata <= comp_value;
            work_wdata <= comp_value;
            // No-operation cycles replace the discarded word(s)
            instr_nop <= (next_state != CSE_RUN);
            skip_taken <= is_cmp && cycle_end && equal;
            busy <= (next_state != CSE_RUN);
        end
    end

    // ==================================================
    // Checks
    property p_skip_kill;
        @(posedge sys_clk) disable iff (reset)
        (is_cmp && cycle_end && equal) |=> (state == CSE_KILL1)
            && instr_nop;
    endproperty
    a_skip_kill: assert property (p_skip_kill)
        else $error("equal compare did not discard next word");

    property p_noskip;
        @(posedge sys_clk) disable iff (reset)
        (is_cmp && cycle_end && !equal) |=> (state == CSE_RUN) && !busy;
    endproperty
    a_noskip: assert property (p_noskip)
        else $error("unequal compare stalled");

    property p_short_skip;
        @(posedge sys_clk) disable iff (reset)
        (state == CSE_KILL1 && cycle_end && !(instr_valid && next_is_long))
            |=> (state == CSE_RUN);
    endproperty
    a_short_skip: assert property (p_short_skip)
        else $error("one-word skip lasted too long");

    property p_long_skip;
        @(posedge sys_clk) disable iff (reset)
        (state == CSE_KILL1 && cycle_end && instr_valid && next_is_long)
            |=> (state == CSE_KILL2) && instr_nop;
    endproperty
    a_long_skip: assert property (p_long_skip)
        else $error("two-word skip missed its extra cycle");

    property p_dead_quiet;
        @(posedge sys_clk) disable iff (reset)
        (state != CSE_RUN) |-> !mem_we && !work_we ##0 $stable(mem_addr);
    endproperty
    a_dead_quiet: assert property (p_dead_quiet)
        else $error("activity during dead cycle");

    property p_cmp_nowrite;
        @(posedge sys_clk) disable iff (reset)
        is_cmp |=> !mem_we && !work_we;
    endproperty
    a_cmp_nowrite: assert property (p_cmp_nowrite)
        else $error("compare wrote a result");

    property p_comp_w;
        @(posedge sys_clk) disable iff (reset)
        (is_comp && !instr[9] && q_phase == CSE_PHASE_READ)
            |=> work_we && !mem_we && (work_wdata == ~$past(mem_rdata));
    endproperty
    a_comp_w: assert property (p_comp_w)
        else $error("complement to working register wrong");

    property p_comp_f;
        @(posedge sys_clk) disable iff (reset)
        (is_comp && instr[9] && q_phase == CSE_PHASE_READ)
            |=> mem_we && !work_we && (mem_wdata == ~$past(mem_rdata));
    endproperty
    a_comp_f: assert property (p_comp_f)
        else $error("complement to register wrong");

    property p_bank;
        @(posedge sys_clk) disable iff (reset)
        ((is_cmp || is_comp) && instr[8]) |=>
            (mem_addr == {$past(bank_select_register), $past(instr[7:0])});
    endproperty
    a_bank: assert property (p_bank)
        else $error("banked address wrong");

    property p_access;
        @(posedge sys_clk) disable iff (reset)
        ((is_cmp || is_comp) && !instr[8] && !ext_enable
            && instr[7:0] < CSE_ACCESS_SPLIT)
            |=> (mem_addr[11:8] == 4'h0);
    endproperty
    a_access: assert property (p_access)
        else $error("access bank address wrong");

    property p_indexed;
        @(posedge sys_clk) disable iff (reset)
        ((is_cmp || is_comp) && !instr[8] && ext_enable
            && instr[7:0] <= CSE_ILO_MAX)
            |=> (mem_addr == $past(index_base) + {4'h0, $past(instr[7:0])});
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");
endmodule
`default_nettype wire

// ### pkg/cse_pkg.sv
// Constants and types for the compare-skip and complement decoder
package cse_pkg;
    // ==================================================
    // Opcode fields, address ranges, reset values and clock phases
    localparam logic [6:0] CSE_OP_CMP_EQ = 7'h31;
    localparam logic [5:0] CSE_OP_COMP = 6'h07;
    localparam logic [3:0] CSE_OP_LONG = 4'hF;
    localparam logic [7:0] CSE_ILO_MAX = 8'h5F;
    localparam logic [3:0] CSE_ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0] CSE_ACCESS_SPLIT = 8'h60;
    localparam logic [11:0] CSE_ADDR_RESET = 12'h000;
    localparam logic [7:0] CSE_BYTE_RESET = 8'h00;
    localparam logic [1:0] CSE_PHASE_LAST = 2'h3;
    localparam logic [1:0] CSE_PHASE_READ = 2'h1;
    localparam logic [1:0] CSE_PHASE_WRITE = 2'h3;

    // ==================================================
    // Execution states
    typedef enum logic [1:0] {
        CSE_RUN = 2'b00,
        CSE_KILL1 = 2'b01,
        CSE_KILL2 = 2'b10
    } cse_state_t;
endpackage

// ### verif/compare_equal_skip_execute_tb_top.sv
// Random and corner-case bench for the compare-skip execute stage
`timescale 1ns/1ps
`default_nettype none
module compare_equal_skip_execute_tb_top import cse_pkg::*;;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] q_phase;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic [15:0] next_word = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic ext_enable = 1'b0;
    logic [11:0] index_base = 12'h000;
    logic [7:0] working_register_alias = 8'h00;
    logic [7:0] mem_rdata, mem_wdata, w_wdata;
    logic [11:0] mem_addr;
    logic mem_we, w_we, instr_nop, skip_taken, busy;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    cse_exec dut_u (.sys_clk(sys_clk), .reset(reset), .q_phase(q_phase),
        .instr(instr), .instr_valid(instr_valid), .next_word(next_word),
        .bank_select_register(bank_select_register),
        .ext_enable(ext_enable), .index_base(index_base),
        .mem_rdata(mem_rdata),
        .working_register_alias(working_register_alias),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .work_we(w_we), .work_wdata(w_wdata), .instr_nop(instr_nop),
        .skip_taken(skip_taken), .busy(busy));
    cse_core_model m_u (.sys_clk(sys_clk), .reset(reset),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .q_phase(q_phase));

    always #12.5 sys_clk = ~sys_clk;
    // ==========================================
    // Hang guard, far above the ~1300 cycles used
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [11:0] exp_addr(input logic [7:0] f,
                                             input logic a);
        if (a) return {bank_select_register, f};
        if (ext_enable && f <= CSE_ILO_MAX) return index_base + {4'h0, f};
        if (f < CSE_ACCESS_SPLIT) return {4'h0, f};
        return {CSE_ACCESS_HI_BANK, f};
    endfunction

    // ==========================================
    // One instruction, then its follower (short complement or long word)
    task automatic run(input int kind, input logic [7:0] f, input logic a,
                       input logic eq, input logic lng);
        logic [11:0] ad, seen_ad;
        logic [7:0] v, wd, wd2;
        logic [7:0] f2;
        logic skip;
        logic [15:0] exp_dead;
        logic [15:0] exp_mw;
        int nops = 0;
        int nbusy = 0;
        int skips = 0;
        int mw = 0;
        int ww = 0;
        do @(posedge sys_clk); while (q_phase !== 2'h3);
        f2 = 8'($urandom);
        instr <= (kind == 0) ? {7'h31, a, f} : {6'h07, kind == 2, a, f};
        instr_valid <= 1'b1;
        next_word <= lng ? 16'hC123 : {6'h07, 1'b1, 1'b1, f2};
        bank_select_register <= 4'($urandom);
        ext_enable <= 1'($urandom);
        index_base <= 12'($urandom);
        working_register_alias <= 8'($urandom);
        #1;
        ad = exp_addr(f, a);
        v = working_register_alias ^ (eq ? 8'h00 : 8'($urandom_range(1, 255)));
        m_u.mem[{bank_select_register, f2}] = 8'($urandom);
        m_u.mem[ad] = v;
        skip = eq && kind == 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (i == 3) begin
                instr <= next_word;
                // Word after the skipped one: a second half only if long
                next_word <= lng ? 16'hF456 : 16'h0000;
            end
            if (i == 7) instr_valid <= 1'b0;
            #1;
            if (i == 1) seen_ad = mem_addr;
            nops += int'(instr_nop === 1'b1);
            nbusy += int'(busy === 1'b1);
            skips += int'(skip_taken === 1'b1);
            if (w_we === 1'b1) wd2 = w_wdata;
            ww += int'(w_we === 1'b1);
            if (mem_we === 1'b1 && mw == 0) wd = mem_wdata;
            mw += int'(mem_we === 1'b1);
        end
        chk("mem_addr", seen_ad, {4'h0, ad});
        // One dead instruction cycle is four clocks
        exp_dead = skip ? (lng ? 16'h0008 : 16'h0004) : 16'h0000;
        exp_mw = 16'(int'(kind == 2) + int'(!skip && !lng));
        chk("nop_cycles", 16'(nops), exp_dead);
        chk("busy_cycles", 16'(nbusy), exp_dead);
        chk("skip_pulse", 16'(skips), {15'h0, skip});
        chk("w_writes", 16'(ww), {15'h0, kind == 1});
        if (kind == 1) chk("w_data", {8'h0, wd2}, {8'h0, ~v});
        chk("mem_writes", 16'(mw), exp_mw);
        if (kind == 2) chk("mem_data", {8'h0, wd}, {8'h0, ~v});
    endtask

    initial begin
        void'($urandom(32'h3047));
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        // Boundaries of indexed and access-bank ranges, both skip lengths
        run(0, 8'h5F, 1'b0, 1'b1, 1'b1);
        run(0, 8'h60, 1'b0, 1'b1, 1'b0);
        run(0, 8'hFF, 1'b1, 1'b0, 1'b0);
        run(1, 8'h13, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 60; i++) begin
            run(int'($urandom_range(0, 2)), 8'($urandom), 1'($urandom),
                1'($urandom), 1'($urandom));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### verif/cse_core_model.sv
// Phase sequencer and data memory beside the execute stage
`timescale 1ns/1ps
`default_nettype none
module cse_core_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [11:0] mem_addr,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic [1:0] q_phase
);
    // ==========================================
    // Storage, preloaded by the bench per test
    logic [7:0] mem [0:4095];
    assign mem_rdata = mem[mem_addr];
    always @(posedge sys_clk) begin
        if (reset) begin
            q_phase <= 2'h0;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire
